//--- rtl/shreg_pkg.sv
// Purpose: shared constants and types of the four-stage universal shift register
// Assumes: one clock (ref_clk, 200 MHz), synchronous active-high reset
// Notes: op code is {op_pick1, op_pick0}
// Behaviour
// - four stages, parallel and serial inputs, outputs
// - both selects high: parallel load on edge
// - parallel load ignores both serial inputs
// - pick0 high, pick1 low: shift toward out3
// - pick0 low, pick1 high: shift toward out0
// - both selects low: stages hold
// - low clear forces all four stage outputs low
// - stages change only on a clock edge, except that a falling clear empties them at once
package shreg_pkg;

   localparam int STAGES = 4;
   localparam int CMD_DEPTH = 16;
   localparam logic [STAGES-1:0] STAGE_RST = 4'h0;

   typedef enum logic [1:0] {
      OP_HOLD  = 2'b00,
      OP_RIGHT = 2'b01,
      OP_LEFT  = 2'b10,
      OP_LOAD  = 2'b11
   } op_t;

   // one queued clocking request: select code plus every data input
   typedef struct packed {
      op_t op;
      logic feed_top_in;
      logic feed_bottom_in;
      logic [STAGES-1:0] par;
   } cmd_t;

   localparam int CMD_W = $bits(cmd_t);

endpackage

//--- rtl/cmd_fifo.sv
// Purpose: request queue with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
module cmd_fifo import shreg_pkg::*; #(
   parameter int WIDTH = CMD_W,
   parameter int DEPTH = CMD_DEPTH
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;

   wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   wire empty = (wr_r == rd_r);
   wire push = in_valid && !full;
   wire pop = out_ready && !empty;

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_r[rd_r[AW-1:0]];
   assign level = wr_r - rd_r;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_r[wr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         wr_r <= wr_r + (AW+1)'(push);
         rd_r <= rd_r + (AW+1)'(pop);
      end
   end

   overflow_a: assert property (@(posedge ref_clk) disable iff (reset)
      full |-> !in_ready && level == DEPTH)
      else $error("queue full flag disagrees with fill level");

endmodule

//--- rtl/stage_mux.sv
// Purpose: next-value select for one stage
// Assumes: neighbours already routed by the caller
// Notes: purely combinational
`timescale 1ns/1ps
module stage_mux import shreg_pkg::*; (
   input op_t op,
   input wire logic cur,
   input wire logic below,
   input wire logic above,
   input wire logic par_bit,
   output logic nxt
);
   wire is_load = (op == OP_LOAD);
   wire is_right = (op == OP_RIGHT);
   wire is_left = (op == OP_LEFT);

   // load takes only the parallel bit, serial feeds never reach it
   assign nxt = is_load ? par_bit :
                is_right ? below :
                is_left ? above :
                cur;

endmodule

//--- rtl/univ_shift4.sv
// Purpose: four-stage bidirectional universal shift register behind a request queue
// Assumes: inputs synchronous to ref_clk; wipe_n may fall at any time
// Notes: each request drained from the queue stands for one rising edge of the register
`timescale 1ns/1ps
module univ_shift4 import shreg_pkg::*; #(
   parameter int DEPTH = CMD_DEPTH
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wipe_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic op_pick0,
   input wire logic op_pick1,
   input wire logic pin0_in,
   input wire logic pin1_in,
   input wire logic pin2_in,
   input wire logic pin3_in,
   input wire logic feed_bottom_in,
   input wire logic feed_top_in,
   input wire logic step_ok,
   output logic out0,
   output logic out1,
   output logic out2,
   output logic out3,
   output logic [$clog2(DEPTH):0] pending
);

   cmd_t cmd_in;
   cmd_t head;
   logic head_valid;
   logic [STAGES-1:0] stage_r;
   logic [STAGES-1:0] stage_nxt;
   logic [STAGES+1:0] ext;

   // mode and data are sampled together as one request
   assign cmd_in.op = op_t'({op_pick1, op_pick0});
   assign cmd_in.feed_top_in = feed_top_in;
   assign cmd_in.feed_bottom_in = feed_bottom_in;
   assign cmd_in.par = {pin3_in, pin2_in, pin1_in, pin0_in};

   cmd_fifo #(
      .WIDTH(CMD_W),
      .DEPTH(DEPTH)
   ) u_queue (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data(cmd_in),
      .out_valid(head_valid),
      .out_ready(step_ok),
      .out_data(head),
      .level(pending)
   );

   // a register edge happens only when a request is drained
   wire fire = head_valid && step_ok;

   // neighbour chain: bottom feed below stage 0, top feed above stage 3
   assign ext = {head.feed_top_in, stage_r, head.feed_bottom_in};

   genvar i;
   generate
      for (i = 0; i < STAGES; i++) begin : g_stage
         stage_mux u_mux (
            .op(head.op),
            .cur(stage_r[i]),
            .below(ext[i]),
            .above(ext[i+2]),
            .par_bit(head.par[i]),
            .nxt(stage_nxt[i])
         );
      end
   endgenerate

   // clear overrides everything, without waiting for the clock
   always_ff @(posedge ref_clk or negedge wipe_n) begin
      if (!wipe_n) begin
         stage_r <= STAGE_RST;
      end else if (reset) begin
         stage_r <= STAGE_RST;
      end else if (fire) begin
         stage_r <= stage_nxt;
      end
   end

   // each stage on its own output
   assign out0 = stage_r[0];
   assign out1 = stage_r[1];
   assign out2 = stage_r[2];
   assign out3 = stage_r[3];

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   wire do_load = fire && head.op == OP_LOAD;
   wire do_right = fire && head.op == OP_RIGHT;
   wire do_left = fire && head.op == OP_LEFT;
   wire do_hold = fire && head.op == OP_HOLD;

   par_load_a: assert property (
      do_load && wipe_n ##1 wipe_n |-> stage_r == $past(head.par))
      else $error("parallel load did not capture inputs");

   load_serial_a: assert property (
      do_load && wipe_n && head.feed_bottom_in != head.par[0] ##1 wipe_n
      |-> out0 != $past(head.feed_bottom_in))
      else $error("serial data entered during load");

   right_shift_a: assert property (
      do_right && wipe_n ##1 wipe_n
      |-> stage_r == {$past(stage_r[2:0]), $past(head.feed_bottom_in)})
      else $error("shift toward out3 wrong");

   left_shift_a: assert property (
      do_left && wipe_n ##1 wipe_n
      |-> stage_r == {$past(head.feed_top_in), $past(stage_r[3:1])})
      else $error("shift toward out0 wrong");

   hold_mode_a: assert property (
      do_hold && wipe_n ##1 wipe_n |-> $stable(stage_r))
      else $error("hold mode changed a stage");

   clear_low_a: assert property (
      !wipe_n |-> {out3, out2, out1, out0} == 4'h0)
      else $error("outputs not low during clear");

   idle_keep_a: assert property (
      !fire && wipe_n ##1 wipe_n |-> $stable(stage_r))
      else $error("stages changed without a drained request");

   sync_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0)
      reset |=> stage_r == STAGE_RST)
      else $error("reset did not clear the stages");

   walk_right_a: assert property (
      do_right && wipe_n ##1 do_right && wipe_n ##1 do_right && wipe_n ##1 wipe_n
      |-> out2 == $past(head.feed_bottom_in, 3) && out3 == $past(stage_r[0], 3))
      else $error("bottom feed did not walk three stages in three steps");

   load_c: cover property (do_load);
   right_c: cover property (do_right ##1 do_right ##1 do_right ##1 do_right);
   left_c: cover property (do_left ##1 do_left);
   clear_c: cover property (stage_r != 4'h0 ##1 !wipe_n);
   full_c: cover property (!cmd_ready && cmd_valid);

endmodule

//--- testbench/drive_side.sv
// Purpose: driving-side model that queues one request at a time
// Assumes: requests launched at falling edges
// Notes: released lines show the inverted last value
`timescale 1ns/1ps
module drive_side import shreg_pkg::*; (
   input wire logic ref_clk,
   input wire logic cmd_ready,
   output logic cmd_valid,
   output cmd_t c
);
   initial begin
      cmd_valid = 1'b0;
      c = '0;
   end
   task automatic send(input op_t o, input logic t, b, input logic [3:0] p, output logic ok);
      ok = 1'b0;
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      c = '{o, t, b, p};
      for (int k = 0; k < 64 && !ok; k++) begin
         ok = cmd_ready;
         @(posedge ref_clk);
         if (!ok) @(negedge ref_clk);
      end
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      c = ~c;
   endtask
endmodule

//--- testbench/tb.sv
// Purpose: self-checking bench of the shift register
// Assumes: inputs change at falling edges
// Notes: q holds {out3, out2, out1, out0}
`timescale 1ns/1ps
module tb import shreg_pkg::*; ();
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic wipe_n = 1'b1;
   logic step_ok = 1'b1;
   logic cmd_valid;
   logic cmd_ready;
   logic ok;
   cmd_t c;
   logic [3:0] q;
   logic [$clog2(CMD_DEPTH):0] pending;
   int mismatches = 0;
   int n_checks = 0;
   initial forever #2.5 ref_clk = ~ref_clk;
   drive_side u_drive_side (.ref_clk(ref_clk), .cmd_ready(cmd_ready),
      .cmd_valid(cmd_valid), .c(c));
   univ_shift4 u_univ_shift4 (.ref_clk(ref_clk), .reset(reset), .wipe_n(wipe_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .op_pick0(c.op[0]),
      .op_pick1(c.op[1]), .pin0_in(c.par[0]), .pin1_in(c.par[1]), .pin2_in(c.par[2]),
      .pin3_in(c.par[3]), .feed_bottom_in(c.feed_bottom_in),
      .feed_top_in(c.feed_top_in), .step_ok(step_ok), .out0(q[0]), .out1(q[1]),
      .out2(q[2]), .out3(q[3]), .pending(pending));
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [4:0] got, input logic [4:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic put(input op_t o, input logic t, b, input logic [3:0] p);
      u_drive_side.send(o, t, b, p, ok);
      if (ok !== 1'b1) begin
         mismatches++;
         report_and_stop();
      end
   endtask
   task automatic op_do(input op_t o, input logic t, b, input logic [3:0] p, e);
      put(o, t, b, p);
      @(negedge ref_clk);
      chk(5'(q), 5'(e));
   endtask
   task automatic s_modes();
      op_do(OP_LOAD, 1'b1, 1'b1, 4'ha, 4'ha);
      op_do(OP_RIGHT, 1'b0, 1'b1, 4'h0, 4'h5);
      op_do(OP_LEFT, 1'b0, 1'b1, 4'hf, 4'h2);
      op_do(OP_HOLD, 1'b1, 1'b1, 4'hf, 4'h2);
      op_do(OP_LEFT, 1'b1, 1'b0, 4'h0, 4'h9);
      op_do(OP_RIGHT, 1'b1, 1'b0, 4'hf, 4'h2);
   endtask
   task automatic s_stall();
      @(negedge ref_clk);
      step_ok = 1'b0;
      put(OP_LOAD, 1'b0, 1'b0, 4'h7);
      @(negedge ref_clk);
      chk(5'(q), 5'h02);
      chk(pending, 5'h01);
      step_ok = 1'b1;
      @(negedge ref_clk);
      chk(5'(q), 5'h07);
   endtask
   task automatic s_wipe();
      @(negedge ref_clk);
      wipe_n = 1'b0;
      #1 chk(5'(q), 5'h00);
      put(OP_LOAD, 1'b1, 1'b1, 4'hf);
      @(negedge ref_clk);
      chk(5'(q), 5'h00);
      wipe_n = 1'b1;
      @(negedge ref_clk);
      chk(5'(q), 5'h00);
   endtask
   task automatic s_fill();
      @(negedge ref_clk);
      step_ok = 1'b0;
      for (int i = 0; i < 16; i++) put(OP_LOAD, 1'b1, 1'b1, 4'(i));
      chk(pending, 5'h10);
      chk(5'(cmd_ready), 5'h00);
      step_ok = 1'b1;
      for (int i = 0; i < 16; i++) begin
         @(negedge ref_clk);
         chk(5'(q), 5'(i));
      end
   endtask
   initial begin
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      s_modes();
      s_stall();
      s_wipe();
      s_fill();
      report_and_stop();
   end
endmodule
